// *** rtl/rrx_params.svh ***
// constants for the return and rotate execution block
`ifndef RRX_PARAMS_SVH
`define RRX_PARAMS_SVH
`define RRX_OP_NOP 14'h0000
`define RRX_OP_RETURN 14'h0008
`define RRX_OP_IRQRET 14'h0009
`define RRX_LITRET_MASK 14'h3c00
`define RRX_LITRET_VAL 14'h3400
`define RRX_ROTL_MASK 14'h3f00
`define RRX_ROTL_VAL 14'h0d00
`define RRX_DEST_BIT 7
`define RRX_FADDR_MSB 6
`define RRX_LIT_MSB 7
`define RRX_DATA_MSB 7
`define RRX_CARRY_POS 8
`define RRX_C_RST 1'b0
`define RRX_GIE_RST 1'b0
`define RRX_GIE_BIT 7
`define RRX_PC_RST 13'h0000
`define RRX_PC_ONE 13'h0001
`define RRX_W_RST 8'h00
`define RRX_CTRL_RST 8'h00
`define RRX_STACK_DEPTH 8
`define RRX_SP_RST 3'h0
`define RRX_SP_ONE 3'h1
`endif

// *** rtl/rrx_pkg.sv ***
// types for the return and rotate execution block
`default_nettype none
package rrx_pkg;
    typedef enum logic [2:0] {
        RRX_OP_NONE = 3'b000,
        RRX_OP_NOPI = 3'b001,
        RRX_OP_RFI = 3'b010,
        RRX_OP_RLW = 3'b011,
        RRX_OP_RET = 3'b100,
        RRX_OP_ROT = 3'b101
    } rrx_op_t;
    typedef enum logic [0:0] {
        RRX_ST_EXEC = 1'b0,
        RRX_ST_FLUSH = 1'b1
    } rrx_state_t;
endpackage : rrx_pkg
`default_nettype wire

// *** rtl/rrx_decode.sv ***
// instruction word decoder for the return and rotate group
`include "rrx_params.svh"
`default_nettype none
module rrx_decode
    import rrx_pkg::*;
(
    // instruction word
    input wire logic [13:0] instr_i,
    // decoded class
    output var rrx_op_t op_o
);
    always_comb
    begin
        if (instr_i == `RRX_OP_NOP)
            op_o = RRX_OP_NOPI;
        else if (instr_i == `RRX_OP_IRQRET)
            op_o = RRX_OP_RFI;
        else if (instr_i == `RRX_OP_RETURN)
            op_o = RRX_OP_RET;
        else if ((instr_i & `RRX_LITRET_MASK) == `RRX_LITRET_VAL)
            op_o = RRX_OP_RLW;
        else if ((instr_i & `RRX_ROTL_MASK) == `RRX_ROTL_VAL)
            op_o = RRX_OP_ROT;
        else
            op_o = RRX_OP_NONE;
    end
endmodule // rrx_decode
`default_nettype wire

// *** rtl/rrx_exec.sv ***
// execution of nop, returns and rotate-left-through-carry
// Behaviour
// - irq return pops stack into program counter
// - irq return sets global irq enable bit
// - all three returns take two cycles
// - literal return loads literal into working register
// - literal return also pops stack into counter
// - plain return pops stack, flags untouched
// - rotate file register left through carry
// - dest 0 to working, 1 to file
`include "rrx_params.svh"
`default_nettype none
module rrx_exec
    import rrx_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    // instruction fetch
    input wire logic [13:0] instr_i,
    output logic [12:0] program_counter_o,
    // call side of the stack
    input wire logic push_i,
    input wire logic [12:0] push_addr_i,
    // file register port
    output logic [6:0] file_addr_o,
    input wire logic [7:0] file_rdata_i,
    output logic file_we_o,
    output logic [7:0] file_wdata_o,
    // core state
    output logic [7:0] work_reg_o,
    output logic carry_o,
    output logic [7:0] irq_control_reg_o,
    output logic busy_o
);
    rrx_op_t op;
    rrx_state_t state_q;
    rrx_state_t state_d;
    logic [12:0] pc_q;
    logic [12:0] pc_d;
    logic [2:0] sp_q;
    logic [2:0] sp_d;
    logic [12:0] stack_q [`RRX_STACK_DEPTH];
    logic [12:0] stack_top;
    logic [7:0] work_q;
    logic [7:0] work_d;
    logic carry_q;
    logic carry_d;
    logic gie_q;
    logic gie_d;
    logic [8:0] rot;
    logic exec;
    logic is_irq_ret;
    logic is_lit_ret;
    logic is_sub_ret;
    logic is_pop;
    logic is_rot;
    logic rot_to_file;
    logic push_ok;

    rrx_decode u_dec
    (
        .instr_i(instr_i),
        .op_o(op)
    );

    // the second cycle of a return discards the fetched word
    assign exec = (state_q == RRX_ST_EXEC);
    assign is_irq_ret = exec && (op == RRX_OP_RFI);
    assign is_lit_ret = exec && (op == RRX_OP_RLW);
    assign is_sub_ret = exec && (op == RRX_OP_RET);
    assign is_pop = is_irq_ret || is_lit_ret || is_sub_ret;
    assign is_rot = exec && (op == RRX_OP_ROT);
    assign rot_to_file = instr_i[`RRX_DEST_BIT];
    // a pop wins over a push in one cycle; a call never pairs with a return
    assign push_ok = push_i && exec && !is_pop;
    assign stack_top = stack_q[sp_q - `RRX_SP_ONE];

    // carry enters at the bottom, the old msb leaves at the top
    assign rot = {file_rdata_i, carry_q};
    assign file_addr_o = instr_i[`RRX_FADDR_MSB:0];
    assign file_we_o = is_rot && rot_to_file;
    assign file_wdata_o = rot[`RRX_DATA_MSB:0];

    // two-cycle sequencer for the returns
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            RRX_ST_EXEC:
                if (is_pop)
                    state_d = RRX_ST_FLUSH;
            RRX_ST_FLUSH:
                state_d = RRX_ST_EXEC;
            default:
                state_d = RRX_ST_EXEC;
        endcase
    end

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            state_q <= RRX_ST_EXEC;
        else
            state_q <= state_d;
    end

    // program counter; nop and unknown words just advance it
    always_comb
    begin
        pc_d = pc_q;
        if (is_pop)
            pc_d = stack_top;
        else if (exec)
            pc_d = pc_q + `RRX_PC_ONE;
    end

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            pc_q <= `RRX_PC_RST;
        else
            pc_q <= pc_d;
    end

    // circular stack: an overflow silently overwrites the oldest entry
    always_comb
    begin
        sp_d = sp_q;
        if (is_pop)
            sp_d = sp_q - `RRX_SP_ONE;
        else if (push_ok)
            sp_d = sp_q + `RRX_SP_ONE;
    end

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            sp_q <= `RRX_SP_RST;
        else
            sp_q <= sp_d;
    end

    // entries need no reset: a pop below a push is a software fault
    always_ff @(posedge mclk_i)
    begin
        if (push_ok)
            stack_q[sp_q] <= push_addr_i;
    end

    // working register
    always_comb
    begin
        work_d = work_q;
        if (is_lit_ret)
            work_d = instr_i[`RRX_LIT_MSB:0];
        else if (is_rot && !rot_to_file)
            work_d = rot[`RRX_DATA_MSB:0];
    end

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            work_q <= `RRX_W_RST;
        else
            work_q <= work_d;
    end

    // only the rotate touches carry; returns leave carry alone, irq return sets the enable bit
    always_comb
    begin
        carry_d = carry_q;
        if (is_rot)
            carry_d = rot[`RRX_CARRY_POS];
    end

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            carry_q <= `RRX_C_RST;
        else
            carry_q <= carry_d;
    end

    // enable bit only; nothing but reset clears it
    always_comb
    begin
        gie_d = gie_q;
        if (is_irq_ret)
            gie_d = 1'b1;
    end

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            gie_q <= `RRX_GIE_RST;
        else
            gie_q <= gie_d;
    end

    // core state outputs
    assign program_counter_o = pc_q;
    assign work_reg_o = work_q;
    assign carry_o = carry_q;
    assign busy_o = !exec;

    always_comb
    begin
        irq_control_reg_o = `RRX_CTRL_RST;
        irq_control_reg_o[`RRX_GIE_BIT] = gie_q;
    end
endmodule // rrx_exec
`default_nettype wire

// *** tb/rrx_exec_assertions.sv ***
// assertions for the return and rotate execution block
`default_nettype none
module rrx_exec_assertions (
    input wire logic mclk_i, nrst_i, push_i, file_we_o, carry_o, busy_o,
    input wire logic [13:0] instr_i,
    input wire logic [12:0] program_counter_o, push_addr_i,
    input wire logic [6:0] file_addr_o,
    input wire logic [7:0] file_rdata_i, file_wdata_o, work_reg_o, irq_control_reg_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    wire rdy = !busy_o;
    wire msb = file_rdata_i[7];
    wire [7:0] lit = instr_i[7:0];
    wire lw = rdy && instr_i[13:10] == 4'hd;
    wire rot = rdy && instr_i[13:8] == 6'h0d;
    wire ret = lw || rdy && (instr_i == 14'h0008 || instr_i == 14'h0009);
    chk_ret_two_cyc: assert property (ret |=> busy_o ##1 !busy_o)
        else $error("return length");
    chk_irq_ret_gie: assert property (rdy && instr_i == 14'h0009 |=> irq_control_reg_o[7])
        else $error("enable bit");
    chk_lit_to_w: assert property (lw |=> work_reg_o == $past(lit))
        else $error("literal");
    chk_ret_keeps: assert property (rdy && instr_i == 14'h0008 |=> $stable(carry_o))
        else $error("flags moved");
    chk_rot_dest: assert property (rot |-> file_we_o == instr_i[7])
        else $error("dest");
    chk_no_write: assert property (!rot |-> !file_we_o)
        else $error("stray write");
    chk_rot_data: assert property (rot |-> file_wdata_o == {file_rdata_i[6:0], carry_o})
        else $error("rotate data");
    chk_rot_carry: assert property (rot |=> carry_o == $past(msb))
        else $error("carry");
    chk_file_addr: assert property (rot |-> file_addr_o == instr_i[6:0])
        else $error("addr");
    chk_nop_pc: assert property (rdy && instr_i == 14'h0000 |=>
        program_counter_o == $past(program_counter_o) + 13'h0001 && !busy_o)
        else $error("nop");
    cover property (ret);
    cover property (rot && instr_i[7]);
    cover property (rot && !instr_i[7]);
endmodule // rrx_exec_assertions
bind rrx_exec rrx_exec_assertions rrx_exec_assertions_inst (.*);
`default_nettype wire

// *** tb/rrx_exec_tb.sv ***
// self-checking bench for the return and rotate execution block
`default_nettype none
`define CHK(n, e, v) begin comparisons++; if ((v) !== (e)) begin errors++; \
    $display("[ERR] %s exp %h got %h", n, e, v); end end
module rrx_exec_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 0, nrst_i = 0, push_i = 0, file_we_o, carry_o, busy_o, wq, c;
    logic [13:0] instr_i = 14'h0000, i;
    logic [12:0] program_counter_o, push_addr_i = 13'h0000, pc;
    logic [6:0] file_addr_o;
    logic [7:0] file_rdata_i = 8'h00, file_wdata_o, work_reg_o, irq_control_reg_o, dq, r, wb;
    logic [31:0] s = 32'h496345cd;
    int errors = 0, comparisons = 0;
    rrx_exec rrx_exec_inst (.*);
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic go(input logic [13:0] op, input logic p);
        @(posedge mclk_i);
        s = lfsr(s);
        instr_i <= op;
        push_i <= p;
        push_addr_i <= s[12:0];
        file_rdata_i <= s[20:13];
        #1;
        wq = file_we_o;
        dq = file_wdata_o;
        @(posedge mclk_i);
        instr_i <= 14'h0000;
        push_i <= 1'b0;
        #1;
    endtask
    task test_done;
        if (errors == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial forever #20 mclk_i = ~mclk_i;
    initial
    begin
        #50000;
        errors++;
        test_done;
    end
    initial
    begin
        repeat (6) @(posedge mclk_i);
        nrst_i <= 1'b1;
        c = 1'b0;
        for (int n = 0; n < 40; n++)
        begin
            i = n == 0 ? 14'h0d7f : n == 1 ? 14'h0dff : {6'h0d, s[31:24]};
            go(i, 1'b0);
            r = s[20:13];
            `CHK("we", i[7], wq)
            if (i[7])
                `CHK("wdata", {r[6:0], c}, dq)
            else
                `CHK("w", {r[6:0], c}, work_reg_o)
            `CHK("carry", r[7], carry_o)
            c = r[7];
            go(14'h0000, 1'b1);
            pc = s[12:0];
            wb = work_reg_o;
            i = n % 3 == 0 ? 14'h0008 : n % 3 == 1 ? 14'h0009 : {6'h34, s[28:21]};
            go(i, 1'b0);
            `CHK("pc", pc, program_counter_o)
            `CHK("busy", 1'b1, busy_o)
            `CHK("c keep", c, carry_o)
            `CHK("w", n % 3 == 2 ? i[7:0] : wb, work_reg_o)
            if (n % 3 == 1)
                `CHK("gie", 1'b1, irq_control_reg_o[7])
        end
        test_done;
    end
endmodule // rrx_exec_tb
`default_nettype wire
